// ### logic/np_regs_pkg.sv
// Package for the autonegotiation next-page register bank.
// Assumes a 16-bit management register port with 16-bit word addresses.
package np_regs_pkg;

    localparam int ADDR_WIDTH = 16;
    localparam int DATA_WIDTH = 16;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [15:0] TX_NEXT_PAGE_LOW_ADDR = 16'h0208;
    localparam logic [15:0] TX_NEXT_PAGE_MID_ADDR = 16'h0209;
    localparam logic [15:0] TX_NEXT_PAGE_HIGH_ADDR = 16'h020A;
    localparam logic [15:0] RX_PARTNER_PAGE_LOW_ADDR = 16'h020B;
    localparam logic [15:0] RX_PARTNER_PAGE_MID_ADDR = 16'h020C;
    localparam logic [15:0] RX_PARTNER_PAGE_HIGH_ADDR = 16'h020D;

    // ****************************************
    // Field positions of the low words
    // ****************************************
    localparam int MORE_PAGES_BIT = 15;
    localparam int PAGE_ACK_BIT = 14;
    localparam int PAGE_ENCODING_BIT = 13;
    localparam int COMPLY_ACK_BIT = 12;
    localparam int SYNC_TOGGLE_BIT = 11;
    localparam int CODE_FIELD_MSB = 10;
    localparam int CODE_FIELD_WIDTH = 11;

    // Software may write only these bits of the transmit low word.
    localparam logic [15:0] TX_LOW_WRITE_MASK = 16'hB7FF;

    // ****************************************
    // Reset values and message codes
    // ****************************************
    localparam logic [15:0] TX_NEXT_PAGE_LOW_RESET = 16'h2001;
    localparam logic [15:0] TX_NEXT_PAGE_MID_RESET = 16'h0000;
    localparam logic [15:0] TX_NEXT_PAGE_HIGH_RESET = 16'h0000;
    localparam logic [15:0] RX_PAGE_RESET = 16'h0000;
    localparam logic [10:0] MSG_CODE_NULL = 11'h001;
    localparam logic [10:0] MSG_CODE_OUI_TAGGED = 11'h005;
    localparam logic [10:0] MSG_CODE_DEVICE_ID = 11'h006;

endpackage

// ### logic/np_capture_word.sv
// One 16-bit holding word that takes a new value on a capture strobe.
// Assumes the capture strobe is synchronous to sys_clk.
`timescale 1ns/1ps
module np_capture_word #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic capture,
    input wire logic [WIDTH-1:0] live_value,
    output logic [WIDTH-1:0] held_value
);
    if (WIDTH < 1) begin : g_bad_width
        $error("np_capture_word: WIDTH must be at least 1");
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            held_value <= '0;
        end else if (clear) begin
            held_value <= '0;
        end else if (capture) begin
            held_value <= live_value;
        end
    end
endmodule

// ### logic/np_regs.sv
// Autonegotiation next-page register bank: transmit page and received page words.
// Assumes a single-cycle management port on sys_clk and an arbitration engine
// that supplies the partner page and consumes the transmit page.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps

// What this block does
// - Autoneg reset restores transmit low word 0x2001
// - Bit 15 is read/write more-pages request
// - Bit 14 acknowledge is read-only, writes ignored
// - Bit 13 selects encoding, resets to one
// - Bit 12 is read/write comply acknowledge
// - Bit 11 toggle always reads zero
// - Bits 10:0 code field, read/write, reset one
// - Middle word 0x0209 read/write, resets zero
// - High word 0x020A read/write, resets zero
// - Received low word read-only, partner fields
// - Low-word read captures mid and high words
// - Middle word read returns captured value
// - High word captured alike, read-only, resets zero
module np_regs
    import np_regs_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic an_reset,
    input wire logic [np_regs_pkg::ADDR_WIDTH-1:0] reg_addr,
    input wire logic [np_regs_pkg::DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [np_regs_pkg::DATA_WIDTH-1:0] reg_rdata,
    input wire logic [47:0] rx_partner_page,
    input wire logic tx_page_taken,
    output logic [47:0] tx_page,
    output logic tx_page_ready
);
    import np_regs_pkg::*;

    // A narrower or wider port would split page words across accesses,
    // which the capture and assembly logic below does not handle.
    if (DATA_W != DATA_WIDTH) begin : g_bad_data_width
        $error("np_regs: DATA_W must equal the 16-bit register width");
    end

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
        hit = (addr == target);
    endfunction

    logic wr_low;
    logic wr_mid;
    logic wr_high;
    logic rd_rx_low;

    assign wr_low = reg_write && hit(reg_addr, TX_NEXT_PAGE_LOW_ADDR);
    assign wr_mid = reg_write && hit(reg_addr, TX_NEXT_PAGE_MID_ADDR);
    assign wr_high = reg_write && hit(reg_addr, TX_NEXT_PAGE_HIGH_ADDR);
    assign rd_rx_low = reg_read && hit(reg_addr, RX_PARTNER_PAGE_LOW_ADDR);

    // ****************************************
    // Transmit page words
    // ****************************************
    logic [15:0] tx_next_page_low;
    logic [15:0] tx_next_page_mid;
    logic [15:0] tx_next_page_high;

    // Acknowledge and toggle are owned by the arbitration engine, so they are
    // held at zero here and the engine inserts its own values on the wire.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_next_page_low <= TX_NEXT_PAGE_LOW_RESET;
        end else if (an_reset) begin
            tx_next_page_low <= TX_NEXT_PAGE_LOW_RESET;
        end else if (wr_low) begin
            tx_next_page_low <= reg_wdata & TX_LOW_WRITE_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_next_page_mid <= TX_NEXT_PAGE_MID_RESET;
        end else if (an_reset) begin
            tx_next_page_mid <= TX_NEXT_PAGE_MID_RESET;
        end else if (wr_mid) begin
            tx_next_page_mid <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_next_page_high <= TX_NEXT_PAGE_HIGH_RESET;
        end else if (an_reset) begin
            tx_next_page_high <= TX_NEXT_PAGE_HIGH_RESET;
        end else if (wr_high) begin
            tx_next_page_high <= reg_wdata;
        end
    end

    // ****************************************
    // Page hand-off to the arbitration engine
    // ****************************************
    // The page is snapshotted on the low-word write, so later writes to the
    // middle or high word cannot corrupt a page already marked ready.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_page <= '0;
        end else if (wr_low && !an_reset) begin
            tx_page <= {tx_next_page_high, tx_next_page_mid,
                        reg_wdata & TX_LOW_WRITE_MASK};
        end
    end

    // A new low-word write wins over a take in the same cycle.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_page_ready <= 1'b0;
        end else if (an_reset) begin
            tx_page_ready <= 1'b0;
        end else if (wr_low) begin
            tx_page_ready <= 1'b1;
        end else if (tx_page_taken) begin
            tx_page_ready <= 1'b0;
        end
    end

    // ****************************************
    // Received page holding words
    // ****************************************
    logic [15:0] rx_partner_page_mid;
    logic [15:0] rx_partner_page_high;

    np_capture_word #(
        .WIDTH(16)
    ) u_hold_mid (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clear(an_reset),
        .capture(rd_rx_low),
        .live_value(rx_partner_page[31:16]),
        .held_value(rx_partner_page_mid)
    );

    np_capture_word #(
        .WIDTH(16)
    ) u_hold_high (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clear(an_reset),
        .capture(rd_rx_low),
        .live_value(rx_partner_page[47:32]),
        .held_value(rx_partner_page_high)
    );

    // ****************************************
    // Read data
    // ****************************************
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            TX_NEXT_PAGE_LOW_ADDR: begin
                next_rdata = tx_next_page_low;
                next_rdata[SYNC_TOGGLE_BIT] = 1'b0;
            end
            TX_NEXT_PAGE_MID_ADDR: begin
                next_rdata = tx_next_page_mid;
            end
            TX_NEXT_PAGE_HIGH_ADDR: begin
                next_rdata = tx_next_page_high;
            end
            RX_PARTNER_PAGE_LOW_ADDR: begin
                next_rdata = rx_partner_page[15:0];
            end
            RX_PARTNER_PAGE_MID_ADDR: begin
                next_rdata = rx_partner_page_mid;
            end
            RX_PARTNER_PAGE_HIGH_ADDR: begin
                next_rdata = rx_partner_page_high;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_low_reset;
        @(posedge sys_clk) disable iff (!nrst)
        an_reset |=> (tx_next_page_low == TX_NEXT_PAGE_LOW_RESET);
    endproperty
    a_low_reset: assert property (p_low_reset) else $error("low word not reset");

    property p_ack_readonly;
        @(posedge sys_clk) disable iff (!nrst)
        1'b1 |=> !tx_next_page_low[PAGE_ACK_BIT];
    endproperty
    a_ack_readonly: assert property (p_ack_readonly) else $error("ack bit set");

    property p_toggle_reads_zero;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_read && reg_addr == TX_NEXT_PAGE_LOW_ADDR) |=> !reg_rdata[SYNC_TOGGLE_BIT];
    endproperty
    a_toggle_reads_zero: assert property (p_toggle_reads_zero) else $error("toggle read 1");

    property p_low_write;
        @(posedge sys_clk) disable iff (!nrst)
        (wr_low && !an_reset) |=> tx_next_page_low ==
            ($past(reg_wdata) & TX_LOW_WRITE_MASK);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low word write lost");

    property p_mid_write;
        @(posedge sys_clk) disable iff (!nrst)
        (wr_mid && !an_reset) |=> tx_next_page_mid == $past(reg_wdata);
    endproperty
    a_mid_write: assert property (p_mid_write) else $error("mid word write lost");

    property p_high_write;
        @(posedge sys_clk) disable iff (!nrst)
        (wr_high && !an_reset) |=> tx_next_page_high == $past(reg_wdata);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high word write lost");

    property p_capture;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_rx_low && !an_reset) |=>
            rx_partner_page_mid == $past(rx_partner_page[31:16]) &&
            rx_partner_page_high == $past(rx_partner_page[47:32]);
    endproperty
    a_capture: assert property (p_capture) else $error("partner words not captured");

    property p_mid_held;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_read && reg_addr == RX_PARTNER_PAGE_MID_ADDR) |=>
            reg_rdata == $past(rx_partner_page_mid);
    endproperty
    a_mid_held: assert property (p_mid_held) else $error("mid read not held value");

    property p_ready;
        @(posedge sys_clk) disable iff (!nrst)
        (wr_low && !an_reset) |=> tx_page_ready ##0
            (tx_page[15:0] == tx_next_page_low);
    endproperty
    a_ready: assert property (p_ready) else $error("page not marked ready");

    property p_low_readback;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_read && reg_addr == TX_NEXT_PAGE_LOW_ADDR) |=>
            reg_rdata == $past(tx_next_page_low);
    endproperty
    a_low_readback: assert property (p_low_readback) else $error("low readback wrong");

    property p_mid_reset;
        @(posedge sys_clk) disable iff (!nrst)
        an_reset |=> (tx_next_page_mid == TX_NEXT_PAGE_MID_RESET);
    endproperty
    a_mid_reset: assert property (p_mid_reset) else $error("mid word not reset");

    property p_high_reset;
        @(posedge sys_clk) disable iff (!nrst)
        an_reset |=> (tx_next_page_high == TX_NEXT_PAGE_HIGH_RESET);
    endproperty
    a_high_reset: assert property (p_high_reset) else $error("high word not reset");

    property p_rx_low_live;
        @(posedge sys_clk) disable iff (!nrst)
        rd_rx_low |=> reg_rdata == $past(rx_partner_page[15:0]);
    endproperty
    a_rx_low_live: assert property (p_rx_low_live) else $error("partner low word wrong");

    property p_hold_stable;
        @(posedge sys_clk) disable iff (!nrst)
        (!rd_rx_low && !an_reset) |=>
            $stable(rx_partner_page_mid) && $stable(rx_partner_page_high);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("held words moved");

    property p_high_held;
        @(posedge sys_clk) disable iff (!nrst)
        (reg_read && reg_addr == RX_PARTNER_PAGE_HIGH_ADDR) |=>
            reg_rdata == $past(rx_partner_page_high);
    endproperty
    a_high_held: assert property (p_high_held) else $error("high read not held value");

    property p_hold_clear;
        @(posedge sys_clk) disable iff (!nrst)
        an_reset |=> (rx_partner_page_mid == RX_PAGE_RESET) &&
            (rx_partner_page_high == RX_PAGE_RESET);
    endproperty
    a_hold_clear: assert property (p_hold_clear) else $error("held words not cleared");

    property p_page_assembled;
        @(posedge sys_clk) disable iff (!nrst)
        (wr_low && !an_reset) |=>
            tx_page[47:16] == $past({tx_next_page_high, tx_next_page_mid});
    endproperty
    a_page_assembled: assert property (p_page_assembled) else $error("page words wrong");

    property p_page_stands;
        @(posedge sys_clk) disable iff (!nrst)
        !(wr_low && !an_reset) |=> $stable(tx_page);
    endproperty
    a_page_stands: assert property (p_page_stands) else $error("page changed");

    property p_take_clears;
        @(posedge sys_clk) disable iff (!nrst)
        (tx_page_taken && !wr_low) |=> !tx_page_ready;
    endproperty
    a_take_clears: assert property (p_take_clears) else $error("ready not cleared");

    property p_write_wins;
        @(posedge sys_clk) disable iff (!nrst)
        (wr_low && tx_page_taken && !an_reset) |=> tx_page_ready;
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("new page lost to take");

    // Read data must fall back to zero outside the cycle after a read, so a
    // host that samples late sees zero rather than a stale word.
    property p_rdata_idle;
        @(posedge sys_clk) disable iff (!nrst)
        !reg_read |=> (reg_rdata == '0);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    c_low_write: cover property (@(posedge sys_clk) disable iff (!nrst) wr_low);
    c_capture: cover property (@(posedge sys_clk) disable iff (!nrst) rd_rx_low);
    c_taken: cover property (@(posedge sys_clk) disable iff (!nrst)
        tx_page_ready && tx_page_taken);
    c_write_wins: cover property (@(posedge sys_clk) disable iff (!nrst)
        wr_low && tx_page_taken);
    c_an_reset_ready: cover property (@(posedge sys_clk) disable iff (!nrst)
        an_reset && tx_page_ready);
endmodule

// ### testbench/np_engine_model.sv
// Model of the arbitration engine beside the next-page register bank.
// Assumes the bench steers the partner page and how long a take is delayed.
`timescale 1ns/1ps
module np_engine_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [47:0] next_rx,
    input wire logic [7:0] take_after,
    input wire logic tx_page_ready,
    output logic [47:0] rx_partner_page,
    output logic tx_page_taken
);
    logic [7:0] wait_count;
    // ****************************************
    // Engine behaviour
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_partner_page <= 48'h0;
        end else begin
            rx_partner_page <= next_rx;
        end
    end
    // A slow engine leaves the page ready for a while, so readiness is seen to stand.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wait_count <= 8'h00;
            tx_page_taken <= 1'b0;
        end else if (tx_page_ready && !tx_page_taken && wait_count >= take_after) begin
            wait_count <= 8'h00;
            tx_page_taken <= 1'b1;
        end else begin
            wait_count <= tx_page_ready ? wait_count + 8'h01 : 8'h00;
            tx_page_taken <= 1'b0;
        end
    end
endmodule

// ### testbench/tb_np_regs.sv
// Self-checking bench for the next-page register bank.
// Assumes the engine model drives the partner page and takes pages.
`timescale 1ns/1ps
module tb_np_regs;
    import np_regs_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic an_reset = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [47:0] rx_partner_page;
    logic tx_page_taken;
    logic [47:0] tx_page;
    logic tx_page_ready;
    logic [47:0] next_rx = 48'h0;
    logic [7:0] take_after = 8'hFF;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #4 sys_clk = ~sys_clk;

    np_regs dut (.sys_clk(sys_clk), .nrst(nrst), .an_reset(an_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .rx_partner_page(rx_partner_page),
        .tx_page_taken(tx_page_taken), .tx_page(tx_page), .tx_page_ready(tx_page_ready));
    np_engine_model engine (.sys_clk(sys_clk), .nrst(nrst), .next_rx(next_rx),
        .take_after(take_after), .tx_page_ready(tx_page_ready),
        .rx_partner_page(rx_partner_page), .tx_page_taken(tx_page_taken));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd_check(input logic [15:0] addr, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        check({32'h0, reg_rdata}, {32'h0, exp});
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset_values();
        rd_check(TX_NEXT_PAGE_LOW_ADDR, 16'h2001);
        rd_check(TX_NEXT_PAGE_MID_ADDR, 16'h0000);
        rd_check(TX_NEXT_PAGE_HIGH_ADDR, 16'h0000);
        rd_check(RX_PARTNER_PAGE_LOW_ADDR, 16'h0000);
        rd_check(RX_PARTNER_PAGE_MID_ADDR, 16'h0000);
        rd_check(RX_PARTNER_PAGE_HIGH_ADDR, 16'h0000);
        wr(16'h0300, 16'hFFFF);
        rd_check(16'h0300, 16'h0000);
        check({47'h0, tx_page_ready}, 48'h0);
    endtask

    task automatic test_tx_page();
        logic [10:0] codes [3];
        codes = '{MSG_CODE_NULL, MSG_CODE_OUI_TAGGED, MSG_CODE_DEVICE_ID};
        wr(TX_NEXT_PAGE_MID_ADDR, 16'hA5A5);
        wr(TX_NEXT_PAGE_HIGH_ADDR, 16'h5A5A);
        wr(TX_NEXT_PAGE_LOW_ADDR, 16'hFFFF);
        check({47'h0, tx_page_ready}, 48'h1);
        check(tx_page, 48'h5A5A_A5A5_B7FF);
        rd_check(TX_NEXT_PAGE_LOW_ADDR, 16'hB7FF);
        rd_check(TX_NEXT_PAGE_MID_ADDR, 16'hA5A5);
        rd_check(TX_NEXT_PAGE_HIGH_ADDR, 16'h5A5A);
        for (int i = 0; i < 3; i++) begin
            wr(TX_NEXT_PAGE_LOW_ADDR, {5'b00100, codes[i]});
            rd_check(TX_NEXT_PAGE_LOW_ADDR, {5'b00100, codes[i]});
            wr(TX_NEXT_PAGE_LOW_ADDR, {5'b00010, codes[i]});
            rd_check(TX_NEXT_PAGE_LOW_ADDR, {5'b00010, codes[i]});
        end
        take_after <= 8'h02;
        for (int i = 0; i < 20 && tx_page_ready; i++) begin
            @(posedge sys_clk);
            #1;
        end
        take_after <= 8'hFF;
        check({47'h0, tx_page_ready}, 48'h0);
        check(tx_page, {32'h5A5A_A5A5, 5'b00010, MSG_CODE_DEVICE_ID});
    endtask

    task automatic test_rx_capture();
        next_rx <= 48'hC3C3_9696_FFFF;
        repeat (2) @(posedge sys_clk);
        rd_check(RX_PARTNER_PAGE_LOW_ADDR, 16'hFFFF);
        next_rx <= 48'h0;
        repeat (2) @(posedge sys_clk);
        rd_check(RX_PARTNER_PAGE_MID_ADDR, 16'h9696);
        rd_check(RX_PARTNER_PAGE_HIGH_ADDR, 16'hC3C3);
        wr(RX_PARTNER_PAGE_MID_ADDR, 16'h1234);
        wr(RX_PARTNER_PAGE_LOW_ADDR, 16'h1234);
        rd_check(RX_PARTNER_PAGE_MID_ADDR, 16'h9696);
        rd_check(RX_PARTNER_PAGE_LOW_ADDR, 16'h0000);
        rd_check(RX_PARTNER_PAGE_HIGH_ADDR, 16'h0000);
    endtask

    task automatic test_an_reset();
        next_rx <= 48'h7777_6666_0000;
        wr(TX_NEXT_PAGE_MID_ADDR, 16'h1234);
        wr(TX_NEXT_PAGE_LOW_ADDR, 16'h8005);
        rd_check(RX_PARTNER_PAGE_LOW_ADDR, 16'h0000);
        @(posedge sys_clk);
        an_reset <= 1'b1;
        @(posedge sys_clk);
        an_reset <= 1'b0;
        #1;
        check({47'h0, tx_page_ready}, 48'h0);
        rd_check(TX_NEXT_PAGE_LOW_ADDR, TX_NEXT_PAGE_LOW_RESET);
        rd_check(TX_NEXT_PAGE_HIGH_ADDR, 16'h0000);
        rd_check(RX_PARTNER_PAGE_HIGH_ADDR, 16'h0000);
        check(tx_page, 48'h5A5A_1234_8005);
        rd_check(TX_NEXT_PAGE_MID_ADDR, 16'h0000);
        rd_check(RX_PARTNER_PAGE_MID_ADDR, 16'h0000);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        test_reset_values();
        test_tx_page();
        test_rx_capture();
        test_an_reset();
        finish_test();
    end
endmodule
